// *** core/cfg_pkg.sv ***
// Constants for the configuration index/data access block
package cfg_pkg;
   localparam int          NUM_REGS        = 14;
   localparam logic [7:0]  LAST_INDEX      = 8'h0D;
   localparam logic [3:0]  IDX_FUNC_ENABLE = 4'h0;
   localparam logic [3:0]  IDX_FUNC_ADDR   = 4'h1;
   localparam logic [3:0]  IDX_POWER_TEST  = 4'h2;
   localparam logic [7:0]  INDEX_RESET     = 8'h00;
   localparam logic [7:0]  INDEX_RSVD_MASK = 8'h9F;
   localparam logic [7:0]  REG_RESET       = 8'h00;
   localparam logic [15:0] ADDR_PAIR0      = 16'h0398;
   localparam logic [15:0] ADDR_PAIR1      = 16'h026E;
   localparam logic [15:0] ADDR_PAIR2      = 16'h015C;
   localparam logic [15:0] ADDR_PAIR3      = 16'h002E;
   localparam int          ADDR_W          = 16;
   localparam int          DEFSET_W        = 5;
endpackage : cfg_pkg

// *** core/cfg_index_data.sv ***
// Configuration index/data register pair with double-write protection
//
// Summary of operation
// - Fourteen configuration registers, selected by index 00h to 0Dh.
// - The first clock after reset release loads enable and address registers from strap-selected defaults, power/test with zero.
// - Remaining registers reset to zero and change only by software.
// - Index register value selects the register a data access reaches.
// - First index read after reset returns the identification byte.
// - Second index read returns 00h before writes, else the written byte.
// - Index bits 5 and 6 read zero, except in the identification byte.
// - A register takes data only on the second consecutive data write.
// - Later index reads return the last value loaded.
// - Data read returns the register selected by the index.
// - Single reads of index or data are accepted at any time.
// - Five straps at reset select one of 31 default sets; codes 1Eh and 1Fh share one.
// - Two straps place the pair at 398h, 26Eh, 15Ch or 2Eh.
`timescale 1ns/1ns
module cfg_index_data
   import cfg_pkg::*;
#(
   parameter logic [7:0] ID_BYTE = 8'h5A // Arbitrary identification value
)(
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire logic [ADDR_W-1:0]   ioAddr,
   input  wire logic                ioRd,
   input  wire logic                ioWr,
   input  wire logic [7:0]          ioWrData,
   input  wire logic [DEFSET_W-1:0] defaultSetStraps,
   input  wire logic [1:0]          pairLocationStraps,
   output logic      [7:0]          ioRdData,
   output logic                     ioRdValid,
   output logic      [7:0]          functionEnableReg,
   output logic      [7:0]          functionAddressReg,
   output logic      [7:0]          powerTestReg
);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  cfgRegs_q [NUM_REGS];
   logic [7:0]  index_q;
   logic        idShown_q;
   logic        firstWrite_q;
   logic        stapLoad_q;
   logic [ADDR_W-1:0] base;
   logic        hitIndex;
   logic        hitData;
   logic        idxValid;
   logic [7:0]  feDef;
   logic [7:0]  faDef;

   // Pair location from straps, taken as static
   always_comb begin
      unique case (pairLocationStraps)
         2'b00: base = ADDR_PAIR0;
         2'b01: base = ADDR_PAIR1;
         2'b10: base = ADDR_PAIR2;
         2'b11: base = ADDR_PAIR3;
      endcase
   end
   assign hitIndex = (ioAddr == base);
   assign hitData  = (ioAddr == (base + ADDR_W'(1)));
   assign idxValid = (index_q <= LAST_INDEX);

   // Default sets; the secondary enable variants collapse to the primary code
   always_comb begin
      feDef = 8'h08;
      faDef = 8'h10;
      unique case (defaultSetStraps)
         5'h00: begin feDef = 8'h4F; faDef = 8'h10; end
         5'h01: begin feDef = 8'h4F; faDef = 8'h11; end
         5'h02: begin feDef = 8'hCF; faDef = 8'h11; end
         5'h03: begin feDef = 8'h4F; faDef = 8'h39; end
         5'h04: begin feDef = 8'h4F; faDef = 8'h24; end
         5'h05: begin feDef = 8'hCF; faDef = 8'h38; end
         5'h06: begin feDef = 8'h4B; faDef = 8'h00; end
         5'h07: begin feDef = 8'h4B; faDef = 8'h01; end
         5'h08: begin feDef = 8'hCB; faDef = 8'h01; end
         5'h09: begin feDef = 8'h4B; faDef = 8'h09; end
         5'h0A: begin feDef = 8'h4B; faDef = 8'h08; end
         5'h0B: begin feDef = 8'hCB; faDef = 8'h08; end
         5'h0C: begin feDef = 8'h0F; faDef = 8'h10; end
         5'h0D: begin feDef = 8'h0F; faDef = 8'h11; end
         5'h0E: begin feDef = 8'h0F; faDef = 8'h39; end
         5'h0F: begin feDef = 8'h0F; faDef = 8'h24; end
         5'h10: begin feDef = 8'h49; faDef = 8'h00; end
         5'h11: begin feDef = 8'h49; faDef = 8'h01; end
         5'h12: begin feDef = 8'hC9; faDef = 8'h01; end
         5'h13: begin feDef = 8'hC9; faDef = 8'h00; end
         5'h14: begin feDef = 8'h07; faDef = 8'h10; end
         5'h15: begin feDef = 8'h07; faDef = 8'h11; end
         5'h16: begin feDef = 8'h07; faDef = 8'h39; end
         5'h17: begin feDef = 8'h07; faDef = 8'h24; end
         5'h18: begin feDef = 8'h47; faDef = 8'h10; end
         5'h19: begin feDef = 8'h47; faDef = 8'h11; end
         5'h1A: begin feDef = 8'hC7; faDef = 8'h11; end
         5'h1B: begin feDef = 8'h47; faDef = 8'h39; end
         5'h1C: begin feDef = 8'h47; faDef = 8'h24; end
         5'h1D: begin feDef = 8'hC7; faDef = 8'h38; end
         default: begin feDef = 8'h08; faDef = 8'h10; end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Index register; reserved bits never stored
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         index_q <= INDEX_RESET;
      end else if (ioWr && hitIndex) begin
         index_q <= ioWrData & INDEX_RSVD_MASK;
      end
   end

   // Identification byte shown once per reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idShown_q <= 1'b0;
      end else if (ioRd && hitIndex) begin
         idShown_q <= 1'b1;
      end
   end

   // Write-count: only back-to-back data writes commit
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         firstWrite_q <= 1'b0;
      end else if (ioWr && hitData) begin
         firstWrite_q <= ~firstWrite_q;
      end else if ((ioRd || ioWr) && (hitIndex || hitData)) begin
         firstWrite_q <= 1'b0;
      end
   end

   // Strap defaults loaded on the first clock after release, not under reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stapLoad_q <= 1'b1;
      end else begin
         stapLoad_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            cfgRegs_q[i] <= REG_RESET;
         end
      end else if (stapLoad_q) begin
         cfgRegs_q[IDX_FUNC_ENABLE] <= feDef;
         cfgRegs_q[IDX_FUNC_ADDR]   <= faDef;
         cfgRegs_q[IDX_POWER_TEST]  <= REG_RESET;
      end else if (ioWr && hitData && firstWrite_q && idxValid) begin
         cfgRegs_q[index_q[3:0]] <= ioWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data registered; valid one cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ioRdData  <= 8'h00;
         ioRdValid <= 1'b0;
      end else begin
         ioRdValid <= ioRd && (hitIndex || hitData);
         if (ioRd && hitIndex) begin
            ioRdData <= idShown_q ? index_q : ID_BYTE;
         end else if (ioRd && hitData) begin
            ioRdData <= idxValid ? cfgRegs_q[index_q[3:0]] : 8'h00;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         functionEnableReg  <= REG_RESET;
         functionAddressReg <= REG_RESET;
         powerTestReg       <= REG_RESET;
      end else begin
         functionEnableReg  <= cfgRegs_q[IDX_FUNC_ENABLE];
         functionAddressReg <= cfgRegs_q[IDX_FUNC_ADDR];
         powerTestReg       <= cfgRegs_q[IDX_POWER_TEST];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_commit_second;
      @(posedge core_clk) disable iff (!rst_n)
      (ioWr && hitData && firstWrite_q && idxValid && !stapLoad_q)
         |=> cfgRegs_q[$past(index_q[3:0])] == $past(ioWrData);
   endproperty
   a_commit_second: assert property (p_commit_second) else $error("second write not committed");

   property p_no_commit_first;
      @(posedge core_clk) disable iff (!rst_n)
      // Index range guard keeps the unused array slots out of the compare
      (ioWr && hitData && !firstWrite_q && idxValid && !stapLoad_q)
         |=> cfgRegs_q[index_q[3:0]] == $past(cfgRegs_q[index_q[3:0]]);
   endproperty
   a_no_commit_first: assert property (p_no_commit_first) else $error("first write committed");

   property p_restart;
      @(posedge core_clk) disable iff (!rst_n)
      ((ioRd && (hitIndex || hitData)) || (ioWr && hitIndex)) |=> !firstWrite_q;
   endproperty
   a_restart: assert property (p_restart) else $error("write count not restarted");

   property p_first_id;
      @(posedge core_clk) disable iff (!rst_n)
      (ioRd && hitIndex && !idShown_q) |=> ioRdValid && ioRdData == ID_BYTE;
   endproperty
   a_first_id: assert property (p_first_id) else $error("no identification byte");

   property p_index_read;
      @(posedge core_clk) disable iff (!rst_n)
      (ioRd && hitIndex && idShown_q) |=> ioRdData == $past(index_q);
   endproperty
   a_index_read: assert property (p_index_read) else $error("index read wrong");

   property p_rsvd;
      @(posedge core_clk) disable iff (!rst_n)
      ioWr && hitIndex |=> index_q[6:5] == 2'b00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved index bits set");

   property p_out_range;
      @(posedge core_clk) disable iff (!rst_n)
      (ioRd && hitData && !idxValid) |=> ioRdData == 8'h00;
   endproperty
   a_out_range: assert property (p_out_range) else $error("out of range read not zero");

   property p_data_read;
      @(posedge core_clk) disable iff (!rst_n)
      (ioRd && hitData && idxValid) |=> ioRdData == $past(cfgRegs_q[index_q[3:0]]);
   endproperty
   a_data_read: assert property (p_data_read) else $error("data read wrong");

   property p_defaults;
      @(posedge core_clk) disable iff (!rst_n)
      stapLoad_q |=> cfgRegs_q[IDX_FUNC_ENABLE] == $past(feDef) ##1 functionEnableReg == $past(feDef, 2);
   endproperty
   a_defaults: assert property (p_defaults) else $error("strap default not loaded");

   // Host accesses may have idle cycles between them, so the covers allow a short gap
   c_double_write: cover property (@(posedge core_clk) disable iff (!rst_n)
      (ioWr && hitData) ##[1:4] (ioWr && hitData && firstWrite_q));
   c_id_then_zero: cover property (@(posedge core_clk) disable iff (!rst_n)
      (ioRd && hitIndex && !idShown_q) ##[1:5] (ioRd && hitIndex));
   c_broken_pair: cover property (@(posedge core_clk) disable iff (!rst_n)
      (ioWr && hitData) ##[1:4] (ioRd && hitData) ##[1:4] (ioWr && hitData));

endmodule : cfg_index_data

// *** verification/cfg_host_model.sv ***
// Host bus model for the configuration index/data pair
`timescale 1ns/1ns
module cfg_host_model
   import cfg_pkg::*;
(
   input  wire logic              core_clk,
   input  wire logic [7:0]        ioRdData,
   input  wire logic              ioRdValid,
   output logic      [ADDR_W-1:0] ioAddr,
   output logic                   ioRd,
   output logic                   ioWr,
   output logic      [7:0]        ioWrData
);
   initial {ioAddr, ioRd, ioWr, ioWrData} = '0;
   // Released lines show the inverse, so a stale value never passes
   task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
                         output logic v);
      @(negedge core_clk);
      {ioAddr, ioWr, ioRd, ioWrData} = {a, wr, ~wr, d};
      @(negedge core_clk);
      {ioAddr, ioWr, ioRd, ioWrData} = {~a, 2'b00, ~d};
      {q, v} = {ioRdData, ioRdValid};
   endtask : access
   // Interrupts taken as masked for the whole task
   task automatic rmw(input logic [15:0] b, input logic [7:0] i, input logic [7:0] d, output logic [7:0] old);
      logic [7:0] q;
      logic       v;
      access(1'b1, b, i, q, v);
      access(1'b0, b + 16'h0001, 8'h00, old, v);
      access(1'b1, b + 16'h0001, d, q, v);
      access(1'b1, b + 16'h0001, d, q, v);
   endtask : rmw
endmodule : cfg_host_model

// *** verification/tb_config_index_data_access.sv ***
// Self-checking bench for the configuration index/data pair
`timescale 1ns/1ns
module tb_config_index_data_access;
   import cfg_pkg::*;
   localparam logic [7:0]  ID_VAL = 8'hC3; // Arbitrary identification value
   localparam int          KIND_MAP [8] = '{0, 1, 1, 1, 2, 3, 3, 4};
   localparam logic [15:0] DEF_SET [32] = '{
      16'h4F10, 16'h4F11, 16'hCF11, 16'h4F39, 16'h4F24, 16'hCF38, 16'h4B00, 16'h4B01,
      16'hCB01, 16'h4B09, 16'h4B08, 16'hCB08, 16'h0F10, 16'h0F11, 16'h0F39, 16'h0F24,
      16'h4900, 16'h4901, 16'hC901, 16'hC900, 16'h0710, 16'h0711, 16'h0739, 16'h0724,
      16'h4710, 16'h4711, 16'hC711, 16'h4739, 16'h4724, 16'hC738, 16'h0810, 16'h0810};
   logic                core_clk = 1'b0;
   logic                rst_n    = 1'b0;
   logic [ADDR_W-1:0]   ioAddr;
   logic                ioRd, ioWr, ioRdValid, v;
   logic [7:0]          ioWrData, ioRdData, funcEnable, funcAddr, powerTest, q, old;
   logic [DEFSET_W-1:0] straps   = '0;
   logic [1:0]          pairSel  = '0;
   logic [15:0]         base;
   logic [31:0]         lfsr     = 32'h71F2;
   int                  err_total = 0, n_tests = 0, cycles = 0, idx;
   int                  cfgModel[$];
   bit                  fresh, pend;

   always #25 core_clk = ~core_clk;

   cfg_index_data #(.ID_BYTE(ID_VAL)) dut (.core_clk(core_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioRd(ioRd),
      .ioWr(ioWr), .ioWrData(ioWrData), .defaultSetStraps(straps), .pairLocationStraps(pairSel),
      .ioRdData(ioRdData), .ioRdValid(ioRdValid), .functionEnableReg(funcEnable), .functionAddressReg(funcAddr),
      .powerTestReg(powerTest));
   cfg_host_model host (.core_clk(core_clk), .ioRdData(ioRdData), .ioRdValid(ioRdValid), .ioAddr(ioAddr),
      .ioRd(ioRd), .ioWr(ioWr), .ioWrData(ioWrData));

   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : step
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results
   // Generous ceiling; a full run needs about 2500 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         results();
      end
   end
   task automatic ports;
      chk(funcEnable, cfgModel[0][7:0]);
      chk(funcAddr, cfgModel[1][7:0]);
      chk(powerTest, cfgModel[2][7:0]);
   endtask : ports
   ////////////////////////////////////////////////////////////////
   // Kinds: 0 index write, 1 data write, 2 index read, 3 data read, 4 foreign address
   task automatic op(input int k, input logic [7:0] d);
      host.access(k < 2 || (k == 4 && d[0]), base + ((k & 1) ? 16'h0001 : (k == 4) ? 16'h0002 : 16'h0000),
                  d, q, v);
      chk({7'h00, v}, {7'h00, k == 2 || k == 3});
      case (k)
         0: begin
            idx = int'(d & INDEX_RSVD_MASK);
            pend = 0;
         end
         1: begin
            if (pend && idx < NUM_REGS) cfgModel[idx] = d;
            pend = !pend;
         end
         2: begin
            chk(q, fresh ? ID_VAL : idx[7:0]);
            fresh = 0;
            pend = 0;
         end
         3: begin
            chk(q, idx < NUM_REGS ? cfgModel[idx][7:0] : 8'h00);
            pend = 0;
         end
         default: ;
      endcase
      @(negedge core_clk);
      ports();
   endtask : op

   initial begin
      for (int p = 0; p < 4; p++) begin
         lfsr = step(lfsr);
         rst_n = 1'b0;
         straps = lfsr[4:0];
         pairSel = p[1:0];
         base = (p == 0) ? ADDR_PAIR0 : (p == 1) ? ADDR_PAIR1 : (p == 2) ? ADDR_PAIR2 : ADDR_PAIR3;
         repeat (8) @(negedge core_clk);
         rst_n = 1'b1;
         repeat (3) @(negedge core_clk);
         cfgModel = {};
         repeat (NUM_REGS) cfgModel.push_back(0);
         cfgModel[0] = DEF_SET[straps][15:8];
         cfgModel[1] = DEF_SET[straps][7:0];
         {fresh, pend, idx} = {1'b1, 1'b0, 32'd0};
         ports();
         op(2, 8'h00);
         op(2, 8'h00);
         for (int i = 0; i < NUM_REGS; i++) begin
            lfsr = step(lfsr);
            host.rmw(base, i[7:0], lfsr[7:0], old);
            chk(old, cfgModel[i][7:0]);
            {cfgModel[i], idx, pend} = {24'd0, lfsr[7:0], i, 1'b0};
            op(3, 8'h00);
         end
         repeat (150) begin
            lfsr = step(lfsr);
            op(KIND_MAP[lfsr[10:8]], lfsr[7] ? lfsr[7:0] : {4'h0, lfsr[3:0]});
         end
      end
      results();
   end
endmodule : tb_config_index_data_access
